// ### ccsr_pkg.sv
/*
 * Package for the chip control and status register group: offsets, field positions,
 * reset values and speed grade encodings.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
package ccsr_pkg;

    // Register byte offsets (aligned words).
    localparam logic [7:0] CCSR_SUSP_OFS  = 8'h00;
    localparam logic [7:0] CCSR_SPEED_OFS = 8'h04;
    localparam logic [7:0] CCSR_MISC_OFS  = 8'h08;

    // Field positions.
    localparam int CCSR_SUSP_SEL_BIT    = 31;
    localparam int CCSR_SPEED_LSB       = 23;
    localparam int CCSR_SPEED_W         = 9;
    localparam int CCSR_PARITY_HOLD_BIT = 12;
    localparam int CCSR_PRIO_LSB        = 0;
    localparam int CCSR_PRIO_W          = 3;
    localparam int CCSR_MISC_RSV_LSB    = 3;
    localparam int CCSR_MISC_RSV_W      = 9;

    // Reset values.
    localparam logic                    CCSR_SUSP_SEL_RST    = 1'b0;
    localparam logic                    CCSR_PARITY_HOLD_RST = 1'b0;
    localparam logic [CCSR_PRIO_W-1:0]  CCSR_PRIO_RST        = 3'h0;
    // Bits 11-3 of the miscellaneous register come out of reset as 0 0100 0011.
    localparam logic [8:0]              CCSR_MISC_RSV_RST    = 9'h043;

    // Decoded speed grade.
    typedef enum logic [2:0] {
        CCSR_GRADE_800,
        CCSR_GRADE_1000,
        CCSR_GRADE_1200,
        CCSR_GRADE_1250,
        CCSR_GRADE_1500,
        CCSR_GRADE_RSVD
    } ccsr_grade_t;

endpackage : ccsr_pkg

// ### ccsr_regs.sv
/*
 * Chip control and status registers behind a classic Wishbone slave: suspension
 * combine select, speed grade status and miscellaneous chip control.
 * The file also carries the assertions and cover properties that guard the block.
 * Assumes a synchronous bus master on clk_i and a speed code strapped stable.
 * Assumes the master keeps one access open at a time and drops stb after each answer.
 * Assumes core suspension, parity reset request and speed code are synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module ccsr_regs
    import ccsr_pkg::*;
#(
    parameter int NUM_CORES = 2
) (
    // Clock and reset.
    input  wire logic                              clk_i,
    input  wire logic                              rst_b_i,
    // Classic Wishbone slave.
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [7:0]                        wb_adr_i,
    input  wire logic [3:0]                        wb_sel_i,
    input  wire logic [31:0]                       wb_dat_i,
    output logic      [31:0]                       wb_dat_o,
    output logic                                   wb_ack_o,
    output logic                                   wb_err_o,
    // Device side.
    input  wire logic [NUM_CORES-1:0]              core_susp_i,
    input  wire logic [ccsr_pkg::CCSR_SPEED_W-1:0] speed_grade_code_i,
    input  wire logic                              parity_rst_req_i,
    output logic                                   susp_o,
    output logic                                   parity_rst_o,
    output logic [ccsr_pkg::CCSR_PRIO_W-1:0]       queue_dma_link_priority_o,
    output ccsr_pkg::ccsr_grade_t                  speed_grade_o
);
    import ccsr_pkg::*;

    // Whole state of the block.
    typedef struct packed {
        logic                    sel;
        logic                    hold;
        logic [CCSR_PRIO_W-1:0]  prio;
        logic [8:0]              rsv;
        logic [31:0]             dat;
        logic                    ack;
        logic                    err;
        logic                    susp;
        logic                    prst;
        ccsr_grade_t             grade;
    } ccsr_state_t;

    ccsr_state_t s_q;
    ccsr_state_t s_d;
    ccsr_grade_t grade_w;
    logic        req_w;
    logic        hit_w;
    logic [31:0] rd_w;
    logic [31:0] wmask_w;

    // Leading-one decode of the strapped code.
    ccsr_speed_decode u_dec (
        .code_i  (speed_grade_code_i),
        .grade_o (grade_w)
    );

    // A new request is one not yet acknowledged; ack drops the cycle after it is given.
    // Without the ack term a master that holds stb into the answer cycle would be
    // served twice, which would repeat a write and pulse ack again.
    assign req_w = wb_cyc_i && wb_stb_i && !s_q.ack && !s_q.err;
    assign hit_w = (wb_adr_i == CCSR_SUSP_OFS) || (wb_adr_i == CCSR_SPEED_OFS)
                   || (wb_adr_i == CCSR_MISC_OFS);

    // Byte lanes expanded to a bit mask.
    // A lane that is not selected keeps its bits, so sel must cover every field written.
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wmask_w[8*i +: 8] = {8{wb_sel_i[i]}};
    end

    // Read multiplexer; unmapped and unused bits read zero, reserved misc bits 11-3 read back what they hold.
    // Reads have no side effects, so a repeated read is always harmless.
    always_comb begin
        rd_w = 32'h0000_0000;
        case (wb_adr_i)
            CCSR_SUSP_OFS:  rd_w[CCSR_SUSP_SEL_BIT] = s_q.sel;
            CCSR_SPEED_OFS: rd_w[CCSR_SPEED_LSB +: CCSR_SPEED_W] = speed_grade_code_i;
            CCSR_MISC_OFS: begin
                rd_w[CCSR_PARITY_HOLD_BIT]                  = s_q.hold;
                rd_w[CCSR_MISC_RSV_LSB +: CCSR_MISC_RSV_W]  = s_q.rsv;
                rd_w[CCSR_PRIO_LSB +: CCSR_PRIO_W]          = s_q.prio;
            end
            default:        rd_w = 32'h0000_0000;
        endcase
    end

    // Next-state logic for bus, registers and device outputs.
    // Ack, err and read data are recomputed every cycle, so each lasts one cycle only.
    always_comb begin
        s_d       = s_q;
        s_d.ack   = req_w && hit_w;
        s_d.err   = req_w && !hit_w;
        s_d.dat   = (req_w && hit_w && !wb_we_i) ? rd_w : 32'h0000_0000;
        if (req_w && hit_w && wb_we_i) begin
            if (wb_adr_i == CCSR_SUSP_OFS && wmask_w[CCSR_SUSP_SEL_BIT]) begin
                s_d.sel = wb_dat_i[CCSR_SUSP_SEL_BIT];
            end
            if (wb_adr_i == CCSR_MISC_OFS) begin
                if (wmask_w[CCSR_PARITY_HOLD_BIT]) begin
                    s_d.hold = wb_dat_i[CCSR_PARITY_HOLD_BIT];
                end
                if (wmask_w[CCSR_PRIO_LSB]) begin
                    s_d.prio = wb_dat_i[CCSR_PRIO_LSB +: CCSR_PRIO_W];
                end
                // Bits 11-3 are writable reserved storage, kept software.
                s_d.rsv = (s_q.rsv & ~wmask_w[CCSR_MISC_RSV_LSB +: CCSR_MISC_RSV_W])
                          | (wb_dat_i[CCSR_MISC_RSV_LSB +: CCSR_MISC_RSV_W]
                             & wmask_w[CCSR_MISC_RSV_LSB +: CCSR_MISC_RSV_W]);
            end
        end
        s_d.susp  = s_q.sel ? (|core_susp_i) : (&core_susp_i);
        s_d.prst  = parity_rst_req_i && !s_q.hold;
        s_d.grade = grade_w;
    end

    // State register.
    // The reset branch loads constants only; the first edge after release loads s_d.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q.sel   <= CCSR_SUSP_SEL_RST;
            s_q.hold  <= CCSR_PARITY_HOLD_RST;
            s_q.prio  <= CCSR_PRIO_RST;
            s_q.rsv   <= CCSR_MISC_RSV_RST;
            s_q.dat   <= 32'h0000_0000;
            s_q.ack   <= 1'b0;
            s_q.err   <= 1'b0;
            s_q.susp  <= 1'b0;
            s_q.prst  <= 1'b0;
            s_q.grade <= CCSR_GRADE_800;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops.
    // No output passes through logic after its flip-flop, so pin timing stays clean.
    assign wb_dat_o                  = s_q.dat;
    assign wb_ack_o                  = s_q.ack;
    assign wb_err_o                  = s_q.err;
    assign susp_o                    = s_q.susp;
    assign parity_rst_o              = s_q.prst;
    assign queue_dma_link_priority_o = s_q.prio;
    assign speed_grade_o             = s_q.grade;

    // Checks; all are sampled on the rising edge and are off while reset is low.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Merge checks look at the core inputs one edge back.
    susp_and_a: assert property (!s_q.sel && $stable(s_q.sel) ##0 1
        |=> susp_o == &$past(core_susp_i)) else $error("and merge wrong");
    susp_or_a: assert property (s_q.sel && $stable(s_q.sel)
        |=> susp_o == |$past(core_susp_i)) else $error("or merge wrong");
    susp_rsv_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == CCSR_SUSP_OFS
        |-> wb_dat_o[30:0] == 31'h0) else $error("reserved bits nonzero");
    speed_ro_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == CCSR_SPEED_OFS
        |-> wb_dat_o[31:23] == $past(speed_grade_code_i)) else $error("speed code bad");
    grade_low_a: assert property (speed_grade_code_i == 9'h003
        |=> speed_grade_o == CCSR_GRADE_1200) else $error("low decode bad");
    grade_mid_a: assert property (speed_grade_code_i[8:3] == 6'h01
        |=> speed_grade_o == CCSR_GRADE_RSVD) else $error("mid decode bad");
    grade_high_a: assert property (speed_grade_code_i[8:5] == 4'h1
        |=> speed_grade_o == CCSR_GRADE_1250) else $error("high decode bad");
    parity_hold_a: assert property (s_q.hold && $stable(s_q.hold)
        |=> !parity_rst_o) else $error("parity reset not held");
    prio_write_a: assert property (req_w && wb_we_i && wb_adr_i == CCSR_MISC_OFS && wb_sel_i[0]
        |=> queue_dma_link_priority_o == $past(wb_dat_i[2:0])) else $error("prio bad");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");

    // Reset values, seen at the first edge after reset is released.
    // select reset value.
    sel_reset_a: assert property ($rose(rst_b_i)
        |-> s_q.sel == CCSR_SUSP_SEL_RST) else $error("select not reset");
    hold_reset_a: assert property ($rose(rst_b_i)
        |-> s_q.hold == CCSR_PARITY_HOLD_RST) else $error("hold not reset");
    prio_reset_a: assert property ($rose(rst_b_i)
        |-> queue_dma_link_priority_o == CCSR_PRIO_RST) else $error("priority not reset");
    // Reserved storage comes out of reset with its fixed pattern.
    rsv_reset_a: assert property ($rose(rst_b_i)
        |-> s_q.rsv == CCSR_MISC_RSV_RST) else $error("reserved bits not reset");

    // Register writes land at the edge that takes the request.
    // select written.
    sel_write_a: assert property (req_w && wb_we_i && wb_adr_i == CCSR_SUSP_OFS
        && wb_sel_i[3] |=> s_q.sel == $past(wb_dat_i[CCSR_SUSP_SEL_BIT]))
        else $error("select write lost");
    hold_write_a: assert property (req_w && wb_we_i && wb_adr_i == CCSR_MISC_OFS
        && wb_sel_i[1] |=> s_q.hold == $past(wb_dat_i[CCSR_PARITY_HOLD_BIT]))
        else $error("hold write lost");
    hold_lane_a: assert property (req_w && wb_we_i && wb_adr_i == CCSR_MISC_OFS
        && !wb_sel_i[1] |=> $stable(s_q.hold)) else $error("hold lane ignored");
    parity_pass_a: assert property (!s_q.hold
        |=> parity_rst_o == $past(parity_rst_req_i)) else $error("parity reset lost");
    speed_write_a: assert property (req_w && wb_we_i && wb_adr_i == CCSR_SPEED_OFS
        |=> $stable(s_q.sel) && $stable(s_q.hold) && $stable(s_q.prio) && $stable(s_q.rsv))
        else $error("speed write changed state");
    // A write to the suspend register leaves the miscellaneous fields alone.
    susp_iso_a: assert property (req_w && wb_we_i && wb_adr_i == CCSR_SUSP_OFS
        |=> $stable(s_q.hold) && $stable(s_q.prio) && $stable(s_q.rsv))
        else $error("suspend write leaked");
    // A write to the miscellaneous register leaves the select alone.
    misc_iso_a: assert property (req_w && wb_we_i && wb_adr_i == CCSR_MISC_OFS
        |=> $stable(s_q.sel)) else $error("misc write leaked");
    // Reads never change a register.
    read_keep_a: assert property (req_w && !wb_we_i
        |=> $stable(s_q.sel) && $stable(s_q.hold) && $stable(s_q.prio) && $stable(s_q.rsv))
        else $error("read changed state");
    // An unmapped access leaves every register alone.
    err_keep_a: assert property (req_w && !hit_w
        |=> $stable(s_q.sel) && $stable(s_q.hold) && $stable(s_q.prio) && $stable(s_q.rsv))
        else $error("unmapped write landed");

    // Read data of each register, shown one edge after the request is taken.
    // priority read back.
    prio_read_a: assert property (wb_ack_o && !$past(wb_we_i)
        && $past(wb_adr_i) == CCSR_MISC_OFS |-> wb_dat_o[2:0] == $past(s_q.prio))
        else $error("priority read bad");
    // Reserved storage reads back what it holds.
    rsv_read_a: assert property (wb_ack_o && !$past(wb_we_i)
        && $past(wb_adr_i) == CCSR_MISC_OFS |-> wb_dat_o[11:3] == $past(s_q.rsv))
        else $error("reserved read bad");
    // Unused high bits of the miscellaneous register read zero.
    misc_high_a: assert property (wb_ack_o && !$past(wb_we_i)
        && $past(wb_adr_i) == CCSR_MISC_OFS |-> wb_dat_o[31:13] == 19'h0_0000)
        else $error("misc high bits nonzero");
    // Low bits of the speed register read zero.
    speed_low_a: assert property (wb_ack_o && !$past(wb_we_i)
        && $past(wb_adr_i) == CCSR_SPEED_OFS |-> wb_dat_o[22:0] == 23'h00_0000)
        else $error("speed low bits nonzero");

    // Bus answer shape: one answer, one cycle after the request, and only then.
    err_pulse_a: assert property (wb_err_o |=> !wb_err_o) else $error("err held");
    answer_excl_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
    answer_time_a: assert property (req_w |=> wb_ack_o || wb_err_o) else $error("no answer");
    ack_cause_a: assert property (wb_ack_o |-> $past(req_w) && $past(hit_w))
        else $error("stray ack");
    err_cause_a: assert property (wb_err_o |-> $past(req_w) && !$past(hit_w))
        else $error("stray err");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("stale read data");

    grade_zero_a: assert property (speed_grade_code_i == 9'h000
        |=> speed_grade_o == CCSR_GRADE_800) else $error("zero decode bad");
    grade_bit0_a: assert property (speed_grade_code_i == 9'h001
        |=> speed_grade_o == CCSR_GRADE_1000) else $error("bit0 decode bad");
    grade_bit2_a: assert property (speed_grade_code_i[8:2] == 7'h01
        |=> speed_grade_o == CCSR_GRADE_1250) else $error("bit2 decode bad");
    grade_bit4_a: assert property (speed_grade_code_i[8:4] == 5'h01
        |=> speed_grade_o == CCSR_GRADE_1500) else $error("bit4 decode bad");
    grade_bit6_a: assert property (speed_grade_code_i[8:6] == 3'h1
        |=> speed_grade_o == CCSR_GRADE_1200) else $error("bit6 decode bad");
    grade_bit7_a: assert property (speed_grade_code_i[8:7] == 2'h1
        |=> speed_grade_o == CCSR_GRADE_1000) else $error("bit7 decode bad");
    grade_bit8_a: assert property (speed_grade_code_i[8]
        |=> speed_grade_o == CCSR_GRADE_800) else $error("bit8 decode bad");

    // Cover points for the main scenarios.
    cov_or_c:    cover property (s_q.sel && susp_o);
    cov_prio_c:  cover property (wb_ack_o && queue_dma_link_priority_o == 3'h7);
    cov_err_c:   cover property (wb_err_o);
    cov_hold_c:  cover property (parity_rst_req_i && s_q.hold);
    cov_rsvd_c:  cover property (speed_grade_o == CCSR_GRADE_RSVD);

endmodule // ccsr_regs

`default_nettype wire

// ### ccsr_speed_decode.sv
/*
 * Leading-one decoder turning the 9-bit speed grade code into a grade.
 * Assumes a code that is stable while the device runs.
 */
`timescale 1ns/1ps
`default_nettype none

module ccsr_speed_decode
    import ccsr_pkg::*;
(
    // Code in.
    input  wire logic [ccsr_pkg::CCSR_SPEED_W-1:0] code_i,
    // Decoded grade out.
    output ccsr_pkg::ccsr_grade_t                  grade_o
);

    // The highest set bit picks the grade; lower bits are don't-care.
    always_comb begin
        grade_o = CCSR_GRADE_800;
        if (code_i[0]) grade_o = CCSR_GRADE_1000;
        if (code_i[1]) grade_o = CCSR_GRADE_1200;
        if (code_i[2]) grade_o = CCSR_GRADE_1250;
        if (code_i[3]) grade_o = CCSR_GRADE_RSVD;
        if (code_i[4]) grade_o = CCSR_GRADE_1500;
        if (code_i[5]) grade_o = CCSR_GRADE_1250;
        if (code_i[6]) grade_o = CCSR_GRADE_1200;
        if (code_i[7]) grade_o = CCSR_GRADE_1000;
        if (code_i[8]) grade_o = CCSR_GRADE_800;
    end

endmodule // ccsr_speed_decode

`default_nettype wire

// ### chip_control_status_regs_tb.sv
/*
 * Self-checking bench for the chip control and status registers.
 * Assumes ccsr_pkg and ccsr_regs are compiled first; one 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module chip_control_status_regs_tb;
    import ccsr_pkg::*;
    logic        clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, er;
    logic        susp_o, parity_rst_o, parity_rst_req_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [1:0]  core_susp_i;
    logic [8:0]  speed_grade_code_i, cd;
    logic [2:0]  queue_dma_link_priority_o;
    ccsr_grade_t speed_grade_o;
    int          miscompares, checks;
    // Expected grade by number of low ones in the code (zero means none).
    ccsr_grade_t gexp [10] = '{CCSR_GRADE_800, CCSR_GRADE_1000, CCSR_GRADE_1200,
        CCSR_GRADE_1250, CCSR_GRADE_RSVD, CCSR_GRADE_1500, CCSR_GRADE_1250,
        CCSR_GRADE_1200, CCSR_GRADE_1000, CCSR_GRADE_800};

    ccsr_regs #(.NUM_CORES(2)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .core_susp_i(core_susp_i),
        .speed_grade_code_i(speed_grade_code_i), .parity_rst_req_i(parity_rst_req_i),
        .susp_o(susp_o), .parity_rst_o(parity_rst_o),
        .queue_dma_link_priority_o(queue_dma_link_priority_o),
        .speed_grade_o(speed_grade_o));

    // Free-running bench clock, 40 ns period.
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // One classic cycle; only the watchdog ends a wait for an answer that never comes.
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Compare and count; a mismatch is reported at once.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    // Let registered outputs catch up, then look between edges.
    task automatic settle();
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {rst_b_i, core_susp_i, speed_grade_code_i, parity_rst_req_i} = 13'h001;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        settle();
        chk("parity_rst_o", 1, parity_rst_o);
        bus(0, CCSR_SUSP_OFS, 4'hF, 0);
        chk("susp_reset", 0, rd);
        bus(0, CCSR_MISC_OFS, 4'hF, 0);
        chk("misc_reset", 32'h0000_0218, rd);
        for (int s = 0; s < 2; s++) begin
            bus(1, CCSR_SUSP_OFS, 4'hF, {s[0], 31'h7FFF_FFFF});
            bus(0, CCSR_SUSP_OFS, 4'hF, 0);
            chk("susp_reg", {s[0], 31'h0}, rd);
            for (int c = 0; c < 4; c++) begin
                @(posedge clk_i);
                core_susp_i <= c[1:0];
                settle();
                chk("susp_o", s ? |c[1:0] : &c[1:0], susp_o);
            end
        end
        // Every leading-one position, with all lower bits set as well.
        for (int i = 0; i < 10; i++) begin
            cd = 9'((10'h001 << i) - 10'h001);
            @(posedge clk_i);
            speed_grade_code_i <= cd;
            settle();
            chk("grade", 32'(gexp[i]), 32'(speed_grade_o));
            bus(1, CCSR_SPEED_OFS, 4'hF, 0);
            bus(0, CCSR_SPEED_OFS, 4'hF, 0);
            chk("speed_reg", {cd, 23'h0}, rd);
        end
        bus(1, CCSR_MISC_OFS, 4'hF, 32'hFFFF_FFFF);
        bus(0, CCSR_MISC_OFS, 4'hF, 0);
        chk("misc_all", 32'h0000_1FFF, rd);
        settle();
        chk("priority", 7, queue_dma_link_priority_o);
        chk("parity_held", 0, parity_rst_o);
        bus(1, CCSR_MISC_OFS, 4'h1, 0);
        bus(0, CCSR_MISC_OFS, 4'hF, 0);
        chk("misc_lane", 32'h0000_1F00, rd);
        // Read-modify-write clears only the hold bit.
        bus(1, CCSR_MISC_OFS, 4'hF, rd & 32'hFFFF_EFFF);
        settle();
        chk("parity_free", 1, parity_rst_o);
        chk("priority_0", 0, queue_dma_link_priority_o);
        bus(1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
        chk("err", 1, er);
        bus(0, 8'h0C, 4'hF, 0);
        chk("err_dat", 0, rd);
        report_and_stop();
    end

    // Watchdog well beyond the roughly 160 cycles the tests need.
    initial begin
        #400000;
        miscompares++;
        report_and_stop();
    end
endmodule // chip_control_status_regs_tb
`default_nettype wire
